//--- core/crs_core.sv
// Behaviour
// - low reset pin holds core in reset
// - fast-set and shift-left-word opcodes rejected
// - multiply and divide execute
// - wait instruction is supported
// - stop instruction is supported
// - accumulator is eight bits wide
// - data moves mainly through the accumulator
// - index X and Y are eight bits
// - indexed address is operand plus index
// - memory mode uses X as second address
// - memory mode result written via X
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module crs_core (
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        reset_pin_n_in,
  input  wire logic        wake_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic      [31:0] prdata_out,
  output logic             pslverr_out,
  output logic             halted_out,
  output logic             osc_run_out
);

  crs_pkg::crs_state_t state_r;
  crs_pkg::crs_state_t state_nxt;

  logic [1:0]  pin_raw;
  logic [1:0]  s1_r;
  logic [1:0]  s2_r;
  logic [1:0]  s3_r;
  logic [1:0]  lvl_r;
  logic        core_rst;
  logic        wake_lvl;
  logic [7:0]  acc_r;
  logic [7:0]  idx_x_r;
  logic [7:0]  idx_y_r;
  logic        mode_t_r;
  logic [7:0]  opc_r;
  logic [7:0]  opnd_r;
  logic [7:0]  ea_r;
  logic [7:0]  ea_nxt;
  logic [7:0]  data1_r;
  logic        illegal_r;
  logic        mem_pend_r;
  logic        acc_ph;
  logic        is_mem;
  logic        core_busy;
  logic        idle;
  logic        reg_go;
  logic        mem_go;
  logic        apb_done;
  logic        cmd_wr;
  logic        wr_refused;
  logic        unmapped;
  logic [31:0] rd_val;
  logic [7:0]  new_opc;
  logic [7:0]  new_opnd;
  logic        opc_mem;
  logic        opc_legal;
  logic [7:0]  mem_addr;
  logic        mem_we;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic [15:0] product;

  // three-stage pin synchronisers, level accepted once stages 2 and 3 agree
  assign pin_raw = {wake_in, reset_pin_n_in};

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_r  <= crs_pkg::PIN_RST;
      s2_r  <= crs_pkg::PIN_RST;
      s3_r  <= crs_pkg::PIN_RST;
      lvl_r <= crs_pkg::PIN_RST;
    end else begin
      s1_r  <= pin_raw;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= (lvl_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
    end
  end

  assign core_rst = ~lvl_r[0];
  assign wake_lvl = lvl_r[1];

  // bus decode
  assign acc_ph    = psel_in & penable_in & ~pready_out;
  assign is_mem    = (paddr_in[11:10] == crs_pkg::MEM_WIN);
  assign core_busy = (state_r == crs_pkg::ST_RD_A) | (state_r == crs_pkg::ST_RD_B) |
                     (state_r == crs_pkg::ST_EXEC);
  assign idle      = (state_r == crs_pkg::ST_IDLE);
  assign reg_go    = acc_ph & ~is_mem;
  assign mem_go    = acc_ph & is_mem & ~core_busy & ~mem_pend_r;
  assign apb_done  = reg_go | (mem_go & pwrite_in) | mem_pend_r;
  assign new_opc   = pwdata_in[crs_pkg::CMD_OPC_LSB +: 8];
  assign new_opnd  = pwdata_in[crs_pkg::CMD_OPND_LSB +: 8];
  assign cmd_wr    = reg_go & pwrite_in & (paddr_in == crs_pkg::OFS_CMD) & idle & ~core_rst;

  always_comb begin
    unmapped   = 1'b0;
    wr_refused = 1'b0;
    rd_val     = 32'h0000_0000;
    case (paddr_in)
      crs_pkg::OFS_ACC: begin
        rd_val     = {24'h00_0000, acc_r};
        wr_refused = ~idle;
      end
      crs_pkg::OFS_IDX_X: begin
        rd_val     = {24'h00_0000, idx_x_r};
        wr_refused = ~idle;
      end
      crs_pkg::OFS_IDX_Y: begin
        rd_val     = {24'h00_0000, idx_y_r};
        wr_refused = ~idle;
      end
      crs_pkg::OFS_MODE: begin
        rd_val[crs_pkg::MODE_M2M_BIT] = mode_t_r;
        wr_refused = ~idle;
      end
      crs_pkg::OFS_CMD: begin
        rd_val[crs_pkg::CMD_OPC_LSB +: 8]  = opc_r;
        rd_val[crs_pkg::CMD_OPND_LSB +: 8] = opnd_r;
        wr_refused = ~idle;
      end
      crs_pkg::OFS_STATUS: begin
        rd_val[crs_pkg::ST_BUSY_BIT]     = core_busy;
        rd_val[crs_pkg::ST_WAIT_BIT]     = (state_r == crs_pkg::ST_WAIT);
        rd_val[crs_pkg::ST_STOP_BIT]     = (state_r == crs_pkg::ST_STOP);
        rd_val[crs_pkg::ST_ILL_BIT]      = illegal_r;
        rd_val[crs_pkg::ST_EA_LSB +: 8]  = ea_r;
      end
      default: begin
        unmapped = 1'b1;
      end
    endcase
  end

  // registered bus answer, one pready pulse per transfer
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      mem_pend_r  <= 1'b0;
    end else begin
      pready_out  <= apb_done;
      pslverr_out <= reg_go & (unmapped | (pwrite_in & wr_refused));
      mem_pend_r  <= mem_go & ~pwrite_in;
      if (mem_pend_r) begin
        prdata_out <= {24'h00_0000, mem_rdata};
      end else if (reg_go & ~pwrite_in) begin
        prdata_out <= rd_val;
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  // opcode classes; excluded and unknown codes are illegal
  always_comb begin
    opc_mem   = 1'b0;
    opc_legal = 1'b1;
    ea_nxt    = new_opnd;
    case (new_opc)
      crs_pkg::OPC_LDA_X, crs_pkg::OPC_STA_X, crs_pkg::OPC_MUL, crs_pkg::OPC_DIV: begin
        opc_mem = 1'b1;
        ea_nxt  = new_opnd + idx_x_r;
      end
      crs_pkg::OPC_LDA_Y, crs_pkg::OPC_STA_Y: begin
        opc_mem = 1'b1;
        ea_nxt  = new_opnd + idx_y_r;
      end
      crs_pkg::OPC_ADD: begin
        opc_mem = 1'b1;
      end
      crs_pkg::OPC_NOP, crs_pkg::OPC_LDA_IMM, crs_pkg::OPC_WAIT, crs_pkg::OPC_STOP: begin
        opc_mem = 1'b0;
      end
      crs_pkg::OPC_FSET, crs_pkg::OPC_SHLW: begin
        opc_legal = 1'b0;
      end
      default: begin
        opc_legal = 1'b0;
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    if (core_rst) begin
      state_nxt = crs_pkg::ST_IDLE;
    end else begin
      case (state_r)
        crs_pkg::ST_IDLE: begin
          if (cmd_wr & opc_legal & opc_mem) begin
            state_nxt = crs_pkg::ST_RD_A;
          end else if (cmd_wr & (new_opc == crs_pkg::OPC_WAIT)) begin
            state_nxt = crs_pkg::ST_WAIT;
          end else if (cmd_wr & (new_opc == crs_pkg::OPC_STOP)) begin
            state_nxt = crs_pkg::ST_STOP;
          end
        end
        crs_pkg::ST_RD_A: state_nxt = crs_pkg::ST_RD_B;
        crs_pkg::ST_RD_B: state_nxt = crs_pkg::ST_EXEC;
        crs_pkg::ST_EXEC: state_nxt = crs_pkg::ST_IDLE;
        crs_pkg::ST_WAIT, crs_pkg::ST_STOP: begin
          if (wake_lvl) begin
            state_nxt = crs_pkg::ST_IDLE;
          end
        end
        default: state_nxt = crs_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r     <= crs_pkg::ST_IDLE;
      halted_out  <= 1'b0;
      osc_run_out <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      halted_out  <= (state_nxt == crs_pkg::ST_WAIT) | (state_nxt == crs_pkg::ST_STOP);
      osc_run_out <= (state_nxt != crs_pkg::ST_STOP);
    end
  end

  // command capture
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      opc_r   <= crs_pkg::OPC_RST;
      opnd_r  <= crs_pkg::IDX_RST;
      ea_r    <= crs_pkg::IDX_RST;
      data1_r <= crs_pkg::ACC_RST;
    end else begin
      if (cmd_wr) begin
        opc_r  <= new_opc;
        opnd_r <= new_opnd;
        ea_r   <= ea_nxt;
      end
      if (state_r == crs_pkg::ST_RD_B) begin
        data1_r <= mem_rdata;
      end
    end
  end

  // sticky illegal flag, write one to clear, set wins
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      illegal_r <= 1'b0;
    end else if (cmd_wr & ~opc_legal) begin
      illegal_r <= 1'b1;
    end else if (reg_go & pwrite_in & (paddr_in == crs_pkg::OFS_STATUS) & pwdata_in[crs_pkg::ST_ILL_BIT]) begin
      illegal_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_t_r <= crs_pkg::MODE_RST;
    end else if (core_rst) begin
      mode_t_r <= crs_pkg::MODE_RST;
    end else if (reg_go & pwrite_in & idle & (paddr_in == crs_pkg::OFS_MODE)) begin
      mode_t_r <= pwdata_in[crs_pkg::MODE_M2M_BIT];
    end
  end

  assign product = 16'(acc_r) * 16'(data1_r);

  // accumulator and index registers
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acc_r   <= crs_pkg::ACC_RST;
      idx_x_r <= crs_pkg::IDX_RST;
      idx_y_r <= crs_pkg::IDX_RST;
    end else if (core_rst) begin
      acc_r   <= crs_pkg::ACC_RST;
      idx_x_r <= crs_pkg::IDX_RST;
      idx_y_r <= crs_pkg::IDX_RST;
    end else if (state_r == crs_pkg::ST_EXEC) begin
      case (opc_r)
        crs_pkg::OPC_LDA_X, crs_pkg::OPC_LDA_Y: acc_r <= data1_r;
        crs_pkg::OPC_ADD: begin
          if (!mode_t_r) begin
            acc_r <= acc_r + data1_r;
          end
        end
        crs_pkg::OPC_MUL: begin
          {idx_y_r, acc_r} <= product;
        end
        crs_pkg::OPC_DIV: begin
          if (data1_r == 8'h00) begin
            acc_r   <= crs_pkg::DIV0_QUOT;
            idx_y_r <= acc_r;
          end else begin
            acc_r   <= acc_r / data1_r;
            idx_y_r <= acc_r % data1_r;
          end
        end
        default: acc_r <= acc_r;
      endcase
    end else if (cmd_wr & (new_opc == crs_pkg::OPC_LDA_IMM)) begin
      acc_r <= new_opnd;
    end else if (reg_go & pwrite_in & idle) begin
      case (paddr_in)
        crs_pkg::OFS_ACC:   acc_r   <= pwdata_in[7:0];
        crs_pkg::OFS_IDX_X: idx_x_r <= pwdata_in[7:0];
        crs_pkg::OFS_IDX_Y: idx_y_r <= pwdata_in[7:0];
        default:            acc_r   <= acc_r;
      endcase
    end
  end

  // memory port: core first, bus only while core is not sequencing
  always_comb begin
    mem_addr  = paddr_in[9:2];
    mem_we    = mem_go & pwrite_in;
    mem_wdata = pwdata_in[7:0];
    case (state_r)
      crs_pkg::ST_RD_A: mem_addr = ea_r;
      crs_pkg::ST_RD_B: mem_addr = idx_x_r;
      crs_pkg::ST_EXEC: begin
        mem_we    = 1'b0;
        mem_addr  = ea_r;
        mem_wdata = acc_r;
        if ((opc_r == crs_pkg::OPC_STA_X) | (opc_r == crs_pkg::OPC_STA_Y)) begin
          mem_we = 1'b1;
        end else if ((opc_r == crs_pkg::OPC_ADD) & mode_t_r) begin
          mem_we    = 1'b1;
          mem_addr  = idx_x_r;
          mem_wdata = mem_rdata + data1_r;
        end
      end
      default: mem_addr = paddr_in[9:2];
    endcase
  end

  crs_mem u_mem (
    .clk_in    (sys_clk_in),
    .rst_in    (sys_rst_in),
    .we_in     (mem_we),
    .addr_in   (mem_addr),
    .wdata_in  (mem_wdata),
    .rdata_out (mem_rdata)
  );

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_pin_reset;
    !lvl_r[0] |=> (state_r == crs_pkg::ST_IDLE) && (acc_r == crs_pkg::ACC_RST) && (idx_x_r == crs_pkg::IDX_RST);
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("core not reset by pin");

  property p_excluded_opc;
    cmd_wr && ((new_opc == crs_pkg::OPC_FSET) || (new_opc == crs_pkg::OPC_SHLW))
      |=> illegal_r && (state_r == crs_pkg::ST_IDLE) && $stable(acc_r);
  endproperty
  a_excluded_opc: assert property (p_excluded_opc) else $error("excluded opcode executed");

  property p_mul;
    (state_r == crs_pkg::ST_EXEC) && (opc_r == crs_pkg::OPC_MUL) && !core_rst
      |=> {idx_y_r, acc_r} == 16'($past(acc_r)) * 16'($past(data1_r));
  endproperty
  a_mul: assert property (p_mul) else $error("multiply result wrong");

  property p_wait;
    cmd_wr && (new_opc == crs_pkg::OPC_WAIT) |=> (state_r == crs_pkg::ST_WAIT) && halted_out && osc_run_out;
  endproperty
  a_wait: assert property (p_wait) else $error("wait did not halt");

  property p_stop;
    cmd_wr && (new_opc == crs_pkg::OPC_STOP) |=> halted_out && !osc_run_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not stop oscillator");

  property p_wake;
    halted_out && wake_lvl |=> !halted_out && osc_run_out && (state_r == crs_pkg::ST_IDLE);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from halt");

  property p_index_y;
    (state_r == crs_pkg::ST_RD_A) && (opc_r == crs_pkg::OPC_LDA_Y) |-> mem_addr == 8'(opnd_r + idx_y_r);
  endproperty
  a_index_y: assert property (p_index_y) else $error("indexed address wrong");

  property p_m2m_addr;
    (state_r == crs_pkg::ST_RD_B) && !core_rst |-> (mem_addr == idx_x_r) ##1 (state_r == crs_pkg::ST_EXEC);
  endproperty
  a_m2m_addr: assert property (p_m2m_addr) else $error("second operand not at index x");

  property p_m2m_wb;
    (state_r == crs_pkg::ST_EXEC) && (opc_r == crs_pkg::OPC_ADD) && mode_t_r && !core_rst
      |-> mem_we && (mem_addr == idx_x_r) ##1 (acc_r == $past(acc_r));
  endproperty
  a_m2m_wb: assert property (p_m2m_wb) else $error("memory mode result not written via x");

  property p_lda;
    (state_r == crs_pkg::ST_EXEC) && (opc_r == crs_pkg::OPC_LDA_X) && !core_rst |=> acc_r == $past(data1_r);
  endproperty
  a_lda: assert property (p_lda) else $error("load did not reach accumulator");

  c_mul: cover property ((state_r == crs_pkg::ST_EXEC) && (opc_r == crs_pkg::OPC_MUL));
  c_m2m: cover property ((state_r == crs_pkg::ST_EXEC) && (opc_r == crs_pkg::OPC_ADD) && mode_t_r);
  c_stop_wake: cover property ((state_r == crs_pkg::ST_STOP) ##1 (state_r == crs_pkg::ST_IDLE));

endmodule
`default_nettype wire

//--- core/crs_pkg.sv
`default_nettype none
package crs_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_ACC    = 12'h000;
  localparam logic [11:0] OFS_IDX_X  = 12'h004;
  localparam logic [11:0] OFS_IDX_Y  = 12'h008;
  localparam logic [11:0] OFS_MODE   = 12'h00c;
  localparam logic [11:0] OFS_CMD    = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  // data memory window: paddr[11:10] == MEM_WIN, byte index in paddr[9:2]
  localparam logic [1:0]  MEM_WIN    = 2'h1;

  // reset values
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [7:0]  IDX_RST    = 8'h00;
  localparam logic [7:0]  OPC_RST    = 8'h00;
  localparam logic        MODE_RST   = 1'b0;
  // synchroniser idle levels: bit0 reset pin (high), bit1 wake (low)
  localparam logic [1:0]  PIN_RST    = 2'h1;

  // field positions
  localparam int MODE_M2M_BIT = 0;
  localparam int CMD_OPC_LSB  = 0;
  localparam int CMD_OPND_LSB = 8;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_WAIT_BIT  = 1;
  localparam int ST_STOP_BIT  = 2;
  localparam int ST_ILL_BIT   = 3;
  localparam int ST_EA_LSB    = 8;

  // opcodes
  localparam logic [7:0] OPC_NOP     = 8'h00;
  localparam logic [7:0] OPC_LDA_IMM = 8'h01;
  localparam logic [7:0] OPC_LDA_X   = 8'h02;
  localparam logic [7:0] OPC_LDA_Y   = 8'h03;
  localparam logic [7:0] OPC_STA_X   = 8'h04;
  localparam logic [7:0] OPC_STA_Y   = 8'h05;
  localparam logic [7:0] OPC_ADD     = 8'h06;
  localparam logic [7:0] OPC_MUL     = 8'h08;
  localparam logic [7:0] OPC_DIV     = 8'h09;
  localparam logic [7:0] OPC_WAIT    = 8'h0a;
  localparam logic [7:0] OPC_STOP    = 8'h0b;
  localparam logic [7:0] OPC_FSET    = 8'h0c;
  localparam logic [7:0] OPC_SHLW    = 8'h0d;
  localparam logic [7:0] DIV0_QUOT   = 8'hff;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RD_A = 6'h02,
    ST_RD_B = 6'h04,
    ST_EXEC = 6'h08,
    ST_WAIT = 6'h10,
    ST_STOP = 6'h20
  } crs_state_t;

endpackage
`default_nettype wire

//--- core/crs_mem.sv
`timescale 1ns/100ps
`default_nettype none
module crs_mem (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       we_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);

  logic [7:0] mem_r [0:255];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_r[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= mem_r[addr_in];
    end
  end

endmodule
`default_nettype wire

//--- test/cpu_core_register_set_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_core_register_set_tb;
  logic        clk;
  logic        rst;
  logic        pin_n;
  logic        wake;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        halted;
  logic        osc_run;
  int          n_fail;
  int          tests_run;
  logic [7:0]  mem_m [256];
  logic [7:0]  acc_m;
  logic [7:0]  x_m;
  logic [7:0]  y_m;

  crs_core dut (.sys_clk_in(clk), .sys_rst_in(rst), .reset_pin_n_in(pin_n), .wake_in(wake),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .halted_out(halted),
    .osc_run_out(osc_run));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize();
    $display("counts: tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      n_fail++;
    end
  endtask

  task automatic hang(input string what);
    $display("CHECK FAILED %0t timeout %s", $time, what);
    n_fail++;
    summarize();
  endtask

  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang("apb");
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, {31'h0, xe}, "write response");
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk({31'h0, e}, 32'h0, "read response");
    chk(r, x, what);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  function automatic logic [11:0] maddr(input logic [7:0] i);
    return {crs_pkg::MEM_WIN, i, 2'h0};
  endfunction

  task automatic poll_idle();
    logic [31:0] s;
    int          i;
    for (i = 0; i < 20; i++) begin
      rd(crs_pkg::OFS_STATUS, s);
      if (s[crs_pkg::ST_BUSY_BIT] === 1'b0) break;
    end
    if (i == 20) hang("busy");
  endtask

  task automatic wait_halt(input logic lvl);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (halted === lvl) break;
    end
    if (i == 40) hang("halt");
  endtask

  task automatic do_op(input logic [7:0] opc, input logic md, input logic div0);
    logic [7:0]  opnd;
    logic [7:0]  ea;
    logic [7:0]  tgt;
    logic [15:0] prod;
    logic [31:0] s;
    opnd  = 8'($urandom);
    acc_m = 8'($urandom);
    x_m   = 8'($urandom);
    y_m   = 8'($urandom);
    ea = opnd + x_m;
    if (opc == crs_pkg::OPC_LDA_Y || opc == crs_pkg::OPC_STA_Y) ea = opnd + y_m;
    if (opc == crs_pkg::OPC_ADD) ea = opnd;
    if (div0) begin
      mem_m[ea] = 8'h00;
      wr(maddr(ea), 32'h0, 1'b0);
    end
    wr(crs_pkg::OFS_ACC, {24'h0, acc_m}, 1'b0);
    wr(crs_pkg::OFS_IDX_X, {24'h0, x_m}, 1'b0);
    wr(crs_pkg::OFS_IDX_Y, {24'h0, y_m}, 1'b0);
    wr(crs_pkg::OFS_MODE, {31'h0, md}, 1'b0);
    wr(crs_pkg::OFS_CMD, {16'h0, opnd, opc}, 1'b0);
    poll_idle();
    tgt = ea;
    case (opc)
      crs_pkg::OPC_LDA_IMM: acc_m = opnd;
      crs_pkg::OPC_LDA_X, crs_pkg::OPC_LDA_Y: acc_m = mem_m[ea];
      crs_pkg::OPC_STA_X, crs_pkg::OPC_STA_Y: mem_m[ea] = acc_m;
      crs_pkg::OPC_ADD: begin
        if (md) begin
          tgt = x_m;
          mem_m[x_m] = mem_m[x_m] + mem_m[opnd];
        end else begin
          acc_m = acc_m + mem_m[opnd];
        end
      end
      crs_pkg::OPC_MUL: begin
        prod = 16'(acc_m) * 16'(mem_m[ea]);
        {y_m, acc_m} = prod;
      end
      crs_pkg::OPC_DIV: begin
        if (mem_m[ea] == 8'h00) begin
          y_m   = acc_m;
          acc_m = crs_pkg::DIV0_QUOT;
        end else begin
          y_m   = acc_m % mem_m[ea];
          acc_m = acc_m / mem_m[ea];
        end
      end
      default: ;
    endcase
    rdchk(crs_pkg::OFS_ACC, {24'h0, acc_m}, "acc after op");
    rdchk(crs_pkg::OFS_IDX_X, {24'h0, x_m}, "x after op");
    rdchk(crs_pkg::OFS_IDX_Y, {24'h0, y_m}, "y after op");
    rdchk(maddr(tgt), {24'h0, mem_m[tgt]}, "memory after op");
    rd(crs_pkg::OFS_STATUS, s);
    if (opc != crs_pkg::OPC_LDA_IMM && opc != crs_pkg::OPC_NOP && !(opc == crs_pkg::OPC_ADD && md))
      chk({24'h0, s[15:8]}, {24'h0, ea}, "ea");
  endtask

  initial begin
    logic [7:0]  opl [9];
    logic [31:0] r;
    logic        e;
    int          k;
    opl = '{crs_pkg::OPC_LDA_IMM, crs_pkg::OPC_LDA_X, crs_pkg::OPC_LDA_Y, crs_pkg::OPC_STA_X,
      crs_pkg::OPC_STA_Y, crs_pkg::OPC_ADD, crs_pkg::OPC_ADD, crs_pkg::OPC_MUL, crs_pkg::OPC_DIV};
    rst = 1'b1;
    pin_n = 1'b1;
    wake = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_fail = 0;
    tests_run = 0;
    k = $urandom(54);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdchk(crs_pkg::OFS_ACC, 32'h0, "acc reset");
    rdchk(crs_pkg::OFS_IDX_X, 32'h0, "x reset");
    rdchk(crs_pkg::OFS_IDX_Y, 32'h0, "y reset");
    rdchk(crs_pkg::OFS_MODE, 32'h0, "mode reset");
    apb(1'b0, 12'h018, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h80000000, "unmapped read");
    wr(12'h01c, 32'h1, 1'b1);
    for (k = 0; k < 3; k++) begin
      r = $urandom;
      wr(12'(4 * k), r, 1'b0);
      rdchk(12'(4 * k), {24'h0, r[7:0]}, "eight bit register");
    end
    $display("test registers done");
    for (k = 0; k < 256; k++) begin
      mem_m[k] = 8'($urandom);
      wr(maddr(8'(k)), {24'h0, mem_m[k]}, 1'b0);
    end
    for (k = 0; k < 36; k++) do_op(opl[k % 9], (k % 9) == 6, 1'b0);
    do_op(crs_pkg::OPC_DIV, 1'b0, 1'b1);
    do_op(crs_pkg::OPC_NOP, 1'b0, 1'b0);
    $display("test operations done");
    opl[0] = crs_pkg::OPC_FSET;
    opl[1] = crs_pkg::OPC_SHLW;
    opl[2] = 8'h07;
    opl[3] = 8'he5;
    for (k = 0; k < 4; k++) begin
      wr(crs_pkg::OFS_ACC, 32'h5a, 1'b0);
      wr(crs_pkg::OFS_CMD, {24'h0, opl[k]}, 1'b0);
      poll_idle();
      rd(crs_pkg::OFS_STATUS, r);
      chk({31'h0, r[crs_pkg::ST_ILL_BIT]}, 32'h1, "illegal flag");
      rdchk(crs_pkg::OFS_ACC, 32'h5a, "acc kept");
      wr(crs_pkg::OFS_STATUS, 32'h8, 1'b0);
      rd(crs_pkg::OFS_STATUS, r);
      chk({31'h0, r[crs_pkg::ST_ILL_BIT]}, 32'h0, "illegal cleared");
    end
    $display("test illegal done");
    for (k = 0; k < 2; k++) begin
      wr(crs_pkg::OFS_CMD, {24'h0, k ? crs_pkg::OPC_STOP : crs_pkg::OPC_WAIT}, 1'b0);
      wait_halt(1'b1);
      chk({31'h0, osc_run}, {31'h0, k == 0}, "oscillator");
      rd(crs_pkg::OFS_STATUS, r);
      chk({30'h0, r[2:1]}, k ? 32'h2 : 32'h1, "halt status");
      wr(crs_pkg::OFS_ACC, 32'h1, 1'b1);
      wake <= 1'b1;
      wait_halt(1'b0);
      chk({31'h0, osc_run}, 32'h1, "oscillator back");
      repeat (4) @(posedge clk);
      wake <= 1'b0;
      repeat (6) @(posedge clk);
      do_op(crs_pkg::OPC_LDA_IMM, 1'b0, 1'b0);
    end
    $display("test wait stop done");
    wr(crs_pkg::OFS_ACC, 32'ha5, 1'b0);
    wr(crs_pkg::OFS_CMD, {24'h0, crs_pkg::OPC_WAIT}, 1'b0);
    wait_halt(1'b1);
    pin_n <= 1'b0;
    wait_halt(1'b0);
    repeat (4) @(posedge clk);
    rdchk(crs_pkg::OFS_ACC, 32'h0, "pin reset acc");
    wr(crs_pkg::OFS_CMD, 32'h7701, 1'b0);
    repeat (6) @(posedge clk);
    rdchk(crs_pkg::OFS_ACC, 32'h0, "held in reset");
    pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    do_op(crs_pkg::OPC_LDA_IMM, 1'b0, 1'b0);
    $display("test pin reset done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, pready}, 32'h0, "ready in reset");
    rst <= 1'b0;
    rdchk(crs_pkg::OFS_ACC, 32'h0, "acc after second reset");
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
